// ==== common/sfpc_pkg.sv ====
// Constants and types of the self-programming flash controller.
package sfpc_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 14;
    localparam int LATCH_W = 5;
    localparam int ROW_WORDS = 32;
    localparam logic [DATA_W-1:0] BLANK_WORD = 14'h3fff;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;

    localparam logic [7:0] OFF_ADDR_LOW = 8'h00;
    localparam logic [7:0] OFF_ADDR_HIGH = 8'h04;
    localparam logic [7:0] OFF_DATA_LOW = 8'h08;
    localparam logic [7:0] OFF_DATA_HIGH = 8'h0c;
    localparam logic [7:0] OFF_CONTROL = 8'h10;
    localparam logic [7:0] OFF_KEY = 8'h14;

    localparam int BIT_RD = 0;
    localparam int BIT_WR = 1;
    localparam int BIT_WRITE_ALLOW = 2;
    localparam int BIT_WRITE_ABORT = 3;
    localparam int BIT_ERASE_SEL = 4;
    localparam int BIT_LATCH_ONLY = 5;
    localparam int BIT_CFG_SPACE = 6;
    localparam int BIT_BUSY = 7;

    localparam logic [1:0] WP_ALL = 2'b00;
    localparam logic [1:0] WP_HALF = 2'b01;
    localparam logic [1:0] WP_QUARTER = 2'b10;
    localparam logic [1:0] WP_OFF = 2'b11;

    localparam int OP_TIME_US = 2000;
    localparam int CLK_KHZ = 25000;
    localparam int OP_CYC = (OP_TIME_US * CLK_KHZ + 999) / 1000;

    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_GOT_FIRST,
        KEY_GOT_SECOND
    } sfpc_key_t;

    typedef enum logic [2:0] {
        OP_IDLE,
        OP_RD_WAIT,
        OP_RD_ARRAY,
        OP_NOP1,
        OP_NOP2,
        OP_STALL
    } sfpc_op_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic bulk_erase;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } sfpc_ext_req_t;
endpackage

// ==== core/sfpc_flash_ctrl.sv ====
// Self-programming flash controller with AHB-Lite register access.
`timescale 1ns/10ps
`default_nettype none
module sfpc_flash_ctrl #(
    parameter int OP_CYCLES = sfpc_pkg::OP_CYC,
    parameter int ARRAY_AW = sfpc_pkg::ADDR_W
) (
    // Clock and resets.
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic por_n,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Core handshake.
    input wire logic irq_entry,
    output logic force_nop,
    output logic core_stall,
    // Configuration word settings.
    input wire logic code_protect_n,
    input wire logic [1:0] self_write_protect,
    // External programmer port.
    input wire sfpc_pkg::sfpc_ext_req_t ext_req,
    output logic [sfpc_pkg::DATA_W-1:0] ext_rdata,
    output logic ext_blocked
);
    localparam int DW = sfpc_pkg::DATA_W;
    localparam int AW = sfpc_pkg::ADDR_W;
    localparam int LW = sfpc_pkg::LATCH_W;
    localparam int WORDS = 1 << ARRAY_AW;

    logic [DW-1:0] mem [WORDS];
    logic [DW-1:0] latch_q [sfpc_pkg::ROW_WORDS];

    logic hreadyout_q;
    logic [31:0] hrdata_q;
    logic pend_q;
    logic pend_write_q;
    logic [7:0] pend_off_q;

    logic [AW-1:0] addr_q;
    logic [DW-1:0] data_q;
    logic rd_q;
    logic wr_q;
    logic write_allow_q;
    logic erase_sel_q;
    logic latch_only_q;
    logic cfg_space_q;
    logic write_abort_q;
    logic op_mark_q;
    logic rst_seen_q;
    logic cp_on_q;
    logic cp_taken_q;
    sfpc_pkg::sfpc_key_t key_q;
    sfpc_pkg::sfpc_op_t op_q;
    logic [31:0] cnt_q;
    logic force_nop_q;
    logic core_stall_q;
    logic [DW-1:0] ext_rdata_q;
    logic ext_blocked_q;

    logic bus_take;
    logic bus_wr;
    logic bus_rd;
    logic [7:0] bus_wbyte;
    logic ctrl_wr;
    logic unlock_ok;
    logic rd_start;
    logic op_done;
    logic wp_hit;
    logic [AW-1:0] wp_limit;
    logic [AW-LW-1:0] row_sel;

    assign hreadyout = hreadyout_q;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign force_nop = force_nop_q;
    assign core_stall = core_stall_q;
    assign ext_rdata = ext_rdata_q;
    assign ext_blocked = ext_blocked_q;

    assign bus_take = hsel & htrans[1] & hready;
    assign bus_wr = pend_q & pend_write_q;
    assign bus_rd = pend_q & ~pend_write_q;
    assign bus_wbyte = hwdata[7:0];
    assign ctrl_wr = bus_wr && (pend_off_q == sfpc_pkg::OFF_CONTROL);
    // Write-start only takes after both keys and with write-allow set.
    assign unlock_ok = ctrl_wr && bus_wbyte[sfpc_pkg::BIT_WR] && !wr_q &&
        !rd_q && (key_q == sfpc_pkg::KEY_GOT_SECOND) &&
        write_allow_q && (op_q == sfpc_pkg::OP_IDLE);
    assign rd_start = ctrl_wr && bus_wbyte[sfpc_pkg::BIT_RD] && !rd_q &&
        !wr_q && (op_q == sfpc_pkg::OP_IDLE);
    assign op_done = (op_q == sfpc_pkg::OP_STALL) && (cnt_q == 32'h0);
    assign row_sel = addr_q[AW-1:LW];

    // Self-write protect covers the bottom of the array.
    always_comb begin
        case (self_write_protect)
            sfpc_pkg::WP_HALF: wp_limit = AW'(WORDS / 2);
            sfpc_pkg::WP_QUARTER: wp_limit = AW'(WORDS / 4);
            default: wp_limit = '0;
        endcase
        if (self_write_protect == sfpc_pkg::WP_ALL) begin
            wp_hit = 1'b1;
        end else begin
            wp_hit = addr_q < wp_limit;
        end
    end

    // Bus slave: one wait state, then the answer stands until the next read.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_q <= 1'b1;
            pend_q <= 1'b0;
            pend_write_q <= 1'b0;
            pend_off_q <= 8'h00;
        end else if (pend_q) begin
            hreadyout_q <= 1'b1;
            pend_q <= 1'b0;
        end else if (bus_take) begin
            hreadyout_q <= 1'b0;
            pend_q <= 1'b1;
            pend_write_q <= hwrite;
            pend_off_q <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0;
        end else if (bus_rd) begin
            case (pend_off_q)
                sfpc_pkg::OFF_ADDR_LOW: hrdata_q <= {24'h0, addr_q[7:0]};
                sfpc_pkg::OFF_ADDR_HIGH: hrdata_q <= {25'h0, addr_q[AW-1:8]};
                sfpc_pkg::OFF_DATA_LOW: hrdata_q <= {24'h0, data_q[7:0]};
                sfpc_pkg::OFF_DATA_HIGH: hrdata_q <= {26'h0, data_q[DW-1:8]};
                sfpc_pkg::OFF_CONTROL: hrdata_q <= {24'h0,
                    op_q != sfpc_pkg::OP_IDLE, cfg_space_q, latch_only_q,
                    erase_sel_q, write_abort_q, write_allow_q, wr_q, rd_q};
                default: hrdata_q <= 32'h0;
            endcase
        end
    end

    // Address pair: high register carries the upper seven bits.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_q <= '0;
        end else if (bus_wr && pend_off_q == sfpc_pkg::OFF_ADDR_LOW) begin
            addr_q[7:0] <= bus_wbyte;
        end else if (bus_wr && pend_off_q == sfpc_pkg::OFF_ADDR_HIGH) begin
            addr_q[AW-1:8] <= hwdata[AW-9:0];
        end
    end

    // Data pair: a finished read overwrites it, ahead of any bus write in the same cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_q <= '0;
        end else if (op_q == sfpc_pkg::OP_RD_ARRAY) begin
            data_q <= cfg_space_q ? '0 : mem[addr_q[ARRAY_AW-1:0]];
        end else if (bus_wr && pend_off_q == sfpc_pkg::OFF_DATA_LOW) begin
            data_q[7:0] <= bus_wbyte;
        end else if (bus_wr && pend_off_q == sfpc_pkg::OFF_DATA_HIGH) begin
            data_q[DW-1:8] <= hwdata[DW-9:0];
        end
    end

    // Control bits that software owns outright.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            write_allow_q <= 1'b0;
            erase_sel_q <= 1'b0;
            latch_only_q <= 1'b0;
            cfg_space_q <= 1'b0;
        end else if (ctrl_wr) begin
            write_allow_q <= bus_wbyte[sfpc_pkg::BIT_WRITE_ALLOW];
            erase_sel_q <= bus_wbyte[sfpc_pkg::BIT_ERASE_SEL];
            latch_only_q <= bus_wbyte[sfpc_pkg::BIT_LATCH_ONLY];
            cfg_space_q <= bus_wbyte[sfpc_pkg::BIT_CFG_SPACE];
        end
    end

    // Key detector steps only on consecutive bus writes.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            key_q <= sfpc_pkg::KEY_IDLE;
        end else if (irq_entry || bus_rd) begin
            key_q <= sfpc_pkg::KEY_IDLE;
        end else if (bus_wr) begin
            if (pend_off_q == sfpc_pkg::OFF_KEY &&
                    bus_wbyte == sfpc_pkg::KEY_FIRST) begin
                key_q <= sfpc_pkg::KEY_GOT_FIRST;
            end else if (pend_off_q == sfpc_pkg::OFF_KEY &&
                    bus_wbyte == sfpc_pkg::KEY_SECOND &&
                    key_q == sfpc_pkg::KEY_GOT_FIRST) begin
                key_q <= sfpc_pkg::KEY_GOT_SECOND;
            end else begin
                key_q <= sfpc_pkg::KEY_IDLE;
            end
        end
    end

    // Operation sequencer for reads, latch loads, erases and programs.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            op_q <= sfpc_pkg::OP_IDLE;
            cnt_q <= 32'h0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            force_nop_q <= 1'b0;
            core_stall_q <= 1'b0;
        end else begin
            case (op_q)
                sfpc_pkg::OP_IDLE: begin
                    if (unlock_ok) begin
                        wr_q <= 1'b1;
                        op_q <= sfpc_pkg::OP_NOP1;
                        force_nop_q <= 1'b1;
                    end else if (rd_start) begin
                        rd_q <= 1'b1;
                        op_q <= sfpc_pkg::OP_RD_WAIT;
                    end
                end
                sfpc_pkg::OP_RD_WAIT: begin
                    op_q <= sfpc_pkg::OP_RD_ARRAY;
                    force_nop_q <= 1'b1;
                end
                sfpc_pkg::OP_RD_ARRAY: begin
                    op_q <= sfpc_pkg::OP_IDLE;
                    force_nop_q <= 1'b0;
                    rd_q <= 1'b0;
                end
                sfpc_pkg::OP_NOP1: begin
                    op_q <= sfpc_pkg::OP_NOP2;
                end
                sfpc_pkg::OP_NOP2: begin
                    force_nop_q <= 1'b0;
                    if (latch_only_q && !erase_sel_q) begin
                        op_q <= sfpc_pkg::OP_IDLE;
                        wr_q <= 1'b0;
                    end else begin
                        op_q <= sfpc_pkg::OP_STALL;
                        core_stall_q <= 1'b1;
                        cnt_q <= 32'(OP_CYCLES - 1);
                    end
                end
                sfpc_pkg::OP_STALL: begin
                    if (cnt_q == 32'h0) begin
                        op_q <= sfpc_pkg::OP_IDLE;
                        core_stall_q <= 1'b0;
                        wr_q <= 1'b0;
                    end else begin
                        cnt_q <= cnt_q - 32'h1;
                    end
                end
                default: begin
                    op_q <= sfpc_pkg::OP_IDLE;
                end
            endcase
        end
    end

    // Write latches: filled one word per unlock, blanked after each erase or program.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < sfpc_pkg::ROW_WORDS; i++) begin
                latch_q[i] <= sfpc_pkg::BLANK_WORD;
            end
        end else if (op_done) begin
            for (int i = 0; i < sfpc_pkg::ROW_WORDS; i++) begin
                latch_q[i] <= sfpc_pkg::BLANK_WORD;
            end
        end else if (op_q == sfpc_pkg::OP_NOP2 && latch_only_q &&
                !erase_sel_q && !cfg_space_q) begin
            latch_q[addr_q[LW-1:0]] <= data_q;
        end
    end

    // Array writes: programmer port first, then self erase and program.
    always_ff @(posedge hclk) begin
        if (ext_req.bulk_erase) begin
            for (int i = 0; i < WORDS; i++) begin
                mem[i] <= sfpc_pkg::BLANK_WORD;
            end
        end else if (ext_req.wr && !cp_on_q && op_q == sfpc_pkg::OP_IDLE) begin
            mem[ext_req.addr[ARRAY_AW-1:0]] <= ext_req.wdata;
        end else if (op_done && !cfg_space_q && !wp_hit) begin
            for (int i = 0; i < sfpc_pkg::ROW_WORDS; i++) begin
                if (erase_sel_q) begin
                    mem[ARRAY_AW'({row_sel, LW'(i)})] <=
                        sfpc_pkg::BLANK_WORD;
                end else begin
                    mem[ARRAY_AW'({row_sel, LW'(i)})] <=
                        mem[ARRAY_AW'({row_sel, LW'(i)})] &
                        latch_q[i];
                end
            end
        end
    end

    // Code protect is caught once after power-up; only bulk erase frees it.
    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            cp_on_q <= 1'b0;
            cp_taken_q <= 1'b0;
        end else if (ext_req.bulk_erase) begin
            cp_on_q <= 1'b0;
            cp_taken_q <= 1'b1;
        end else if (!cp_taken_q) begin
            cp_on_q <= ~code_protect_n;
            cp_taken_q <= 1'b1;
        end
    end

    // Programmer reads return zero while code protect holds.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_rdata_q <= '0;
            ext_blocked_q <= 1'b0;
        end else begin
            ext_blocked_q <= cp_on_q;
            if (ext_req.rd) begin
                ext_rdata_q <= cp_on_q ? '0 :
                    mem[ext_req.addr[ARRAY_AW-1:0]];
            end
        end
    end

    // Marks a running erase or program across a device reset.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_seen_q <= 1'b0;
        end else begin
            rst_seen_q <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            op_mark_q <= 1'b0;
        end else if (!rst_seen_q || op_done) begin
            op_mark_q <= 1'b0;
        end else if (op_q == sfpc_pkg::OP_NOP2 &&
                !(latch_only_q && !erase_sel_q)) begin
            op_mark_q <= 1'b1;
        end
    end

    // The abort flag survives device reset; a set beats a software clear.
    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            write_abort_q <= 1'b0;
        end else if (!rst_seen_q && op_mark_q) begin
            write_abort_q <= 1'b1;
        end else if (ctrl_wr && !bus_wbyte[sfpc_pkg::BIT_WRITE_ABORT]) begin
            write_abort_q <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ==== test/sfpc_props.sv ====
// Checker of bus timing, core handshake and programmer port.
`timescale 1ns/10ps
`default_nettype none
module sfpc_props #(
    parameter int OP_CYCLES = 20
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Bus.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Core and programmer.
    input wire logic force_nop,
    input wire logic core_stall,
    input wire sfpc_pkg::sfpc_ext_req_t ext_req,
    input wire logic [sfpc_pkg::DATA_W-1:0] ext_rdata,
    input wire logic ext_blocked
);
    logic [31:0] cnt_q;
    logic take;
    assign take = hsel && htrans[1] && hready;
    // Counts the cycles of the current stall.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 32'h0;
        end else if (core_stall) begin
            cnt_q <= cnt_q + 32'h1;
        end else begin
            cnt_q <= 32'h0;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_wait; take |=> !hreadyout ##1 hreadyout; endproperty
    a_wait: assert property (p_wait) else $error("bus wait wrong");
    property p_resp; hresp == 1'b0; endproperty
    a_resp: assert property (p_resp) else $error("bus response wrong");
    property p_key;
        take && !hwrite && haddr[7:0] == 8'h14 |-> ##2 hrdata == 32'h0;
    endproperty
    a_key: assert property (p_key) else $error("key read not zero");
    property p_rd;
        (take && hwrite && haddr[7:0] == 8'h10 && !core_stall && !force_nop)
        ##1 (hwdata[0] && !hwdata[1])
        |=> !force_nop ##1 force_nop ##1 !force_nop;
    endproperty
    a_rd: assert property (p_rd) else $error("read slot wrong");
    property p_nop; $rose(force_nop) |-> ##[1:2] !force_nop; endproperty
    a_nop: assert property (p_nop) else $error("nop slots wrong");
    property p_stall_nop; $rose(core_stall) |-> $fell(force_nop); endproperty
    a_stall_nop: assert property (p_stall_nop) else $error("early");
    property p_stall; $fell(core_stall) |-> cnt_q == OP_CYCLES; endproperty
    a_stall: assert property (p_stall) else $error("stall length");
    property p_excl; core_stall |-> !force_nop; endproperty
    a_excl: assert property (p_excl) else $error("nop in stall");
    property p_prot;
        ext_req.rd && ext_blocked && !ext_req.bulk_erase
        && !$past(ext_req.bulk_erase) |=> ext_rdata == 14'h0;
    endproperty
    a_prot: assert property (p_prot) else $error("read leaks");
    property p_bulk; ext_req.bulk_erase |-> ##2 !ext_blocked; endproperty
    a_bulk: assert property (p_bulk) else $error("bulk no release");
endmodule
bind sfpc_flash_ctrl sfpc_props #(.OP_CYCLES(OP_CYCLES)) u_props (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .force_nop(force_nop), .core_stall(core_stall), .ext_req(ext_req),
    .ext_rdata(ext_rdata), .ext_blocked(ext_blocked)
);
`default_nettype wire

// ==== test/sfpc_core_model.sv ====
// Processor core model issuing register transfers as firmware does.
`timescale 1ns/10ps
`default_nettype none
module sfpc_core_model (
    // Clock and answers.
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic force_nop,
    input wire logic core_stall,
    // Bus requests and interrupt entry.
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    output logic irq_entry
);
    logic [31:0] q;
    initial begin
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        irq_entry = 1'b0;
    end
    task automatic slot();
        @(posedge hclk);
        #1;
    endtask
    task automatic hold();
        logic r;
        do begin
            r = hready;
            slot();
        end while (!r);
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        hold();
        htrans <= 2'b00;
        hwdata <= d;
        hold();
        q = hrdata;
    endtask
    task automatic irq();
        irq_entry <= 1'b1;
        slot();
        irq_entry <= 1'b0;
    endtask
    task automatic rd_word(input logic [14:0] ad, output logic [13:0] v);
        bus(1'b1, 8'h00, {24'h0, ad[7:0]});
        bus(1'b1, 8'h04, {25'h0, ad[14:8]});
        bus(1'b1, 8'h10, 32'h1);
        repeat (2) slot();
        bus(1'b0, 8'h08, 32'h0);
        v[7:0] = q[7:0];
        bus(1'b0, 8'h0c, 32'h0);
        v[13:8] = q[5:0];
    endtask
    task automatic unlock(input logic [7:0] c, input logic wt);
        // Write-allow must already stand when the start write arrives.
        bus(1'b1, 8'h10, {24'h0, c});
        bus(1'b1, 8'h14, 32'h55);
        bus(1'b1, 8'h14, 32'haa);
        bus(1'b1, 8'h10, {24'h0, c | 8'h02});
        if (wt) begin
            repeat (2) slot();
            for (int i = 0; i < 99 && (core_stall || force_nop); i++) slot();
        end
    endtask
    task automatic op(input logic [14:0] ad, input logic [13:0] d,
                      input logic [7:0] c);
        bus(1'b1, 8'h00, {24'h0, ad[7:0]});
        bus(1'b1, 8'h04, {25'h0, ad[14:8]});
        bus(1'b1, 8'h08, {24'h0, d[7:0]});
        bus(1'b1, 8'h0c, {26'h0, d[13:8]});
        unlock(c, 1'b1);
    endtask
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench for the flash controller with a word-level model.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic por_n = 1'b0;
    logic hsel, hwrite, hreadyout, irq_entry, force_nop, core_stall;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [1:0] swp = sfpc_pkg::WP_OFF;
    sfpc_pkg::sfpc_ext_req_t ext_req = '0;
    logic [13:0] ext_rdata, v;
    logic ext_blocked;
    logic [13:0] mem [int];
    logic [13:0] lat [int];
    int n_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    always #20 hclk = ~hclk;
    sfpc_flash_ctrl #(.OP_CYCLES(20)) DUT (
        .hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(), .hrdata(hrdata), .irq_entry(irq_entry),
        .force_nop(force_nop), .core_stall(core_stall),
        .code_protect_n(1'b0), .self_write_protect(swp), .ext_req(ext_req),
        .ext_rdata(ext_rdata), .ext_blocked(ext_blocked)
    );
    sfpc_core_model c (
        .hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
        .force_nop(force_nop), .core_stall(core_stall), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .irq_entry(irq_entry)
    );
    task automatic tally_and_finish();
        if (n_errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic bit prot(int a);
        case (swp)
            sfpc_pkg::WP_ALL: return 1'b1;
            sfpc_pkg::WP_HALF: return a < 16384;
            sfpc_pkg::WP_QUARTER: return a < 8192;
            default: return 1'b0;
        endcase
    endfunction
    task automatic row(input int b);
        for (int k = 0; k < 32; k++) begin
            c.rd_word(15'(b + k), v);
            chk("word", {18'h0, mem[b + k]}, {18'h0, v});
        end
    endtask
    task automatic erase(input int b);
        c.op(15'(b + $urandom % 32), 14'h0, 8'h14);
        if (!prot(b))
            for (int k = 0; k < 32; k++) mem[b + k] = sfpc_pkg::BLANK_WORD;
    endtask
    // The program step repeats the last address and data but loads no latch.
    task automatic prog(input int b, input int n);
        int a;
        logic [13:0] d;
        for (int i = 0; i < n; i++) begin
            a = b + $urandom % 32;
            d = 14'($urandom);
            c.op(15'(a), d, 8'h24);
            lat[a] = d;
        end
        c.op(15'(a), d, 8'h04);
        foreach (lat[k]) mem[k] &= lat[k];
        lat.delete();
    endtask
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    initial begin
        void'($urandom(32'haf3cfb3f));
        repeat (20) @(posedge hclk);
        #1;
        hresetn <= 1'b1;
        por_n <= 1'b1;
        c.slot();
        c.bus(1'b0, 8'h10, 32'h0);
        chk("ctrl", 32'h0, c.q);
        c.bus(1'b1, 8'h14, 32'h55);
        c.bus(1'b0, 8'h14, 32'h0);
        chk("key", 32'h0, c.q);
        c.bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, c.q);
        erase(96);
        row(96);
        prog(96, 6);
        row(96);
        prog(96, 2);
        row(96);
        for (int m = 0; m < 4; m++) begin
            if (m == 3) begin
                c.op(15'd96, 14'h0, 8'h10);
            end else begin
                c.bus(1'b1, 8'h10, 32'h14);
                c.bus(1'b1, 8'h14, 32'h55);
                case (m)
                    0: c.bus(1'b0, 8'h00, 32'h0);
                    1: c.irq();
                    default: c.bus(1'b1, 8'h14, 32'h12);
                endcase
                c.bus(1'b1, 8'h14, 32'haa);
                c.bus(1'b1, 8'h10, 32'h16);
                c.bus(1'b0, 8'h10, 32'h0);
                chk("wr bit", 32'h0, c.q & 32'h2);
            end
        end
        row(96);
        erase(8192);
        for (int m = 0; m < 4; m++) begin
            prog(8192, 1);
            swp <= 2'(m);
            erase(8192);
            swp <= sfpc_pkg::WP_OFF;
            row(8192);
        end
        c.unlock(8'h14, 1'b0);
        c.bus(1'b1, 8'h10, 32'h0);
        c.bus(1'b0, 8'h10, 32'h0);
        chk("wr held", 32'h82, c.q & 32'h82);
        hresetn <= 1'b0;
        repeat (3) c.slot();
        hresetn <= 1'b1;
        c.slot();
        c.bus(1'b0, 8'h10, 32'h0);
        chk("abort", 32'h8, c.q & 32'h8);
        c.bus(1'b1, 8'h10, 32'h0);
        c.bus(1'b0, 8'h10, 32'h0);
        chk("abort clear", 32'h0, c.q & 32'h8);
        chk("blocked", 32'h1, {31'h0, ext_blocked});
        ext_req.addr <= 15'd96;
        ext_req.wr <= 1'b1;
        c.slot();
        ext_req.wr <= 1'b0;
        ext_req.rd <= 1'b1;
        c.slot();
        ext_req.rd <= 1'b0;
        chk("ext read", 32'h0, {18'h0, ext_rdata});
        row(96);
        ext_req.bulk_erase <= 1'b1;
        c.slot();
        ext_req.bulk_erase <= 1'b0;
        repeat (2) c.slot();
        chk("blocked", 32'h0, {31'h0, ext_blocked});
        ext_req.rd <= 1'b1;
        c.slot();
        ext_req.rd <= 1'b0;
        chk("ext read", 32'h3fff, {18'h0, ext_rdata});
        tally_and_finish();
    end
endmodule
`default_nettype wire
